// file: src/kms_pkg.sv
// Package for the key matrix scanner: register map, field layout, reset values and timing
package kms_pkg;
	// Matrix geometry
	localparam int unsigned MAX_ROWS   = 8;
	localparam int unsigned MAX_COLS   = 20;
	localparam int unsigned MAX_KEYS   = 160;
	localparam int unsigned FIFO_DEPTH = 16;
	// Scan clock timing: one key position per tick of the low-power scan rate
	localparam longint unsigned SYS_CLK_HZ  = 250_000_000;
	localparam longint unsigned SCAN_CLK_HZ = 128_000;
	localparam int unsigned     SCAN_DIV    = int'(SYS_CLK_HZ / SCAN_CLK_HZ);
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA   = 8'h08;
	localparam logic [7:0] ADDR_MOD0   = 8'h0C;
	localparam int unsigned MOD_WORDS  = 5;
	// Control field positions
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_COLS_LSB = 8;
	localparam int unsigned CTRL_ROWS_LSB = 16;
	// Status field positions
	localparam int unsigned ST_GHOST_BIT = 0;
	localparam int unsigned ST_OVF_BIT   = 1;
	localparam int unsigned ST_MOD_BIT   = 2;
	localparam int unsigned ST_CLKR_BIT  = 3;
	localparam int unsigned ST_FSM_LSB   = 4;
	localparam int unsigned ST_CNT_LSB   = 8;
	// Data register field positions
	localparam int unsigned DATA_VALID_BIT = 8;
	// Reset values
	localparam logic [4:0] RST_COLS = 5'h14;
	localparam logic [3:0] RST_ROWS = 4'h8;

	// Control register content
	typedef struct packed {
		logic       enable;
		logic [4:0] cols;
		logic [3:0] rows;
	} kms_ctrl_type;

	typedef enum logic [1:0] {
		KMS_IDLE,
		KMS_SCAN,
		KMS_END
	} kms_state_type;
endpackage

// file: src/kms_scanner.sv
// Key matrix scanner: column drive, row sampling, debounce, ghost lockout, key FIFO, APB registers
// Operation
// - Clock request stays low whenever the scanner is disabled.
// - Enabled scanner drops its request in idle and raises it on key sense.
// - Keys are scanned one by one over an 8 by 20 matrix.
// - Column count is programmable from 1 to 20.
// - Row count is programmable from 1 to 8.
// - Key indices go into a 16 byte hardware key code buffer.
// - One key position per 128 kHz tick, full matrix in about 1.25 ms.
// - Any number of keys reported; ghosted keys are locked out selectively.
// - Buffered keys stay until read by software; a key found with the buffer full is dropped.
// - Row samples are glitch filtered and key presses debounced.
// - Machine starts in idle with every column driven high.
// - Row transition in idle requests the clock and enters scan.
// - Idle clears the row-hit register and the key-index counter.
// - Row counter wraps at row count, column advances; both terminal ends scan.
// - Key-index counter advances with each scanned key position.
// - Modifier keys are kept out of the buffer; other keys are stored.
// - Row inputs join the row-hit register only for multi-hit columns.
// - Hit on a row already marked by an earlier column sets ghost status.
// - Scan-end rescans if keys were seen, else idles and drops the request.
// - Key status register is readable at any time.
`timescale 1ns/1ps
`default_nettype none
module kms_scanner
	import kms_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SCAN_DIV
) (
	input  wire logic                clk_sys,
	input  wire logic                sys_rst,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [MAX_ROWS-1:0] row_in,
	output logic      [MAX_COLS-1:0] col_out,
	output logic                     clk_req
);

	kms_ctrl_type              ctrl_q;
	kms_state_type             state_q;
	logic [MAX_ROWS-1:0]       row_s1_q, row_s2_q, row_s3_q;
	logic [MAX_ROWS-1:0]       row_mask, row_f, cur_rows;
	logic [11:0]               tick_cnt_q;
	logic                      tick;
	logic [3:0]                row_q;
	logic [4:0]                col_q;
	logic [7:0]                key_idx_q;
	logic [MAX_ROWS-1:0]       rowhit_q, colrows_q;
	logic                      colmulti_q, cur_multi;
	logic                      any_hit_q;
	logic [MAX_KEYS-1:0]       prev_q, stable_q, mod_map_q;
	logic                      hit, ghost_now, new_press, push_req, mod_ev;
	logic                      ghost_q, ovf_q, mod_seen_q;
	logic [7:0]                fifo_mem [FIFO_DEPTH];
	logic [3:0]                wr_ptr_q, rd_ptr_q;
	logic [4:0]                count_q;
	logic                      pop, push_ok, apb_done, apb_wr;
	logic [31:0]               rd_d;
	logic [1:0]                state_code;
	logic                      last_row, last_col;

	// Number of set bits in a row vector
	function automatic logic [3:0] pop_rows(input logic [MAX_ROWS-1:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < MAX_ROWS; i++) begin
			n = n + {3'b000, v[i]};
		end
		return n;
	endfunction

	// Mask of the programmed rows
	always_comb begin
		row_mask = '0;
		for (int i = 0; i < MAX_ROWS; i++) begin
			row_mask[i] = (4'(i) < ctrl_q.rows);
		end
	end

	// Two-flop synchroniser plus one filter stage on the row pins
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			row_s1_q <= '0;
			row_s2_q <= '0;
			row_s3_q <= '0;
		end else begin
			row_s1_q <= row_in;
			row_s2_q <= row_s1_q;
			row_s3_q <= row_s2_q;
		end
	end

	// A row counts as hit only when two successive samples agree, so single-cycle spikes vanish
	assign row_f = row_s2_q & row_s3_q & row_mask;

	// Scan-rate tick; divider only runs while the clock is requested
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !clk_req) begin
			tick_cnt_q <= '0;
		end else if (tick) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 12'h001;
		end
	end
	assign tick = clk_req && (tick_cnt_q == 12'(TICK_CYCLES - 1));

	// Per-position scan decisions
	// Reaching or passing the end closes the column, so a geometry write mid-pass cannot run off the matrix
	assign last_row  = (row_q >= ctrl_q.rows - 4'h1);
	assign last_col  = (col_q >= ctrl_q.cols - 5'h01);
	assign cur_rows  = (row_q == 4'h0) ? row_f : colrows_q;
	assign cur_multi = (row_q == 4'h0) ? (pop_rows(row_f) >= 4'h2) : colmulti_q;
	assign hit       = cur_rows[row_q[2:0]];
	assign ghost_now = hit && rowhit_q[row_q[2:0]];
	assign new_press = hit && prev_q[key_idx_q] && !stable_q[key_idx_q];
	// Ghosted keys are withheld; other keys in the same pass are still reported
	assign push_req  = (state_q == KMS_SCAN) && tick && new_press && !ghost_now
		&& !mod_map_q[key_idx_q];
	assign mod_ev    = (state_q == KMS_SCAN) && tick && new_press && !ghost_now && mod_map_q[key_idx_q];

	// Scan state machine, counters and clock request
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state_q    <= KMS_IDLE;
			clk_req    <= 1'b0;
			col_out    <= '1;
			row_q      <= '0;
			col_q      <= '0;
			key_idx_q  <= '0;
			rowhit_q   <= '0;
			colrows_q  <= '0;
			colmulti_q <= 1'b0;
			any_hit_q  <= 1'b0;
		end else if (!ctrl_q.enable) begin
			state_q   <= KMS_IDLE;
			clk_req   <= 1'b0;
			col_out   <= '1;
			key_idx_q <= '0;
			rowhit_q  <= '0;
		end else begin
			unique case (state_q)
				KMS_IDLE: begin
					col_out   <= '1;
					key_idx_q <= '0;
					rowhit_q  <= '0;
					row_q     <= '0;
					col_q     <= '0;
					any_hit_q <= 1'b0;
					// Any edge on a row wakes the scanner
					if ((row_s2_q ^ row_s3_q) != '0) begin
						clk_req <= 1'b1;
						state_q <= KMS_SCAN;
						col_out <= MAX_COLS'(1);
					end else begin
						clk_req <= 1'b0;
					end
				end
				KMS_SCAN: begin
					if (tick) begin
						key_idx_q <= key_idx_q + 8'h01;
						if (hit) begin
							any_hit_q <= 1'b1;
						end
						if (row_q == 4'h0) begin
							colrows_q  <= row_f;
							colmulti_q <= cur_multi;
						end
						if (last_row) begin
							row_q <= '0;
							// Only multi-hit columns can create ghosts in later columns
							if (cur_multi) begin
								rowhit_q <= rowhit_q | cur_rows;
							end
							if (last_col) begin
								state_q <= KMS_END;
								col_out <= '1;
							end else begin
								col_q   <= col_q + 5'h01;
								col_out <= MAX_COLS'(1) << (col_q + 5'h01);
							end
						end else begin
							row_q <= row_q + 4'h1;
						end
					end
				end
				KMS_END: begin
					key_idx_q <= '0;
					rowhit_q  <= '0;
					row_q     <= '0;
					col_q     <= '0;
					any_hit_q <= 1'b0;
					if (any_hit_q) begin
						state_q <= KMS_SCAN;
						col_out <= MAX_COLS'(1);
					end else begin
						state_q <= KMS_IDLE;
						clk_req <= 1'b0;
						col_out <= '1;
					end
				end
				// An illegal code falls back to idle, where every column is parked high
				default: begin
					state_q <= KMS_IDLE;
					clk_req <= 1'b0;
					col_out <= '1;
				end
			endcase
		end
	end

	// Debounce memory: a press counts after two agreeing passes, a release after two empty ones
	always_ff @(posedge clk_sys) begin
		if (sys_rst || (state_q == KMS_IDLE)) begin
			prev_q   <= '0;
			stable_q <= '0;
		end else if ((state_q == KMS_SCAN) && tick) begin
			prev_q[key_idx_q] <= hit;
			if (hit && prev_q[key_idx_q]) begin
				stable_q[key_idx_q] <= 1'b1;
			end else if (!hit && !prev_q[key_idx_q]) begin
				stable_q[key_idx_q] <= 1'b0;
			end
		end
	end

	// Key code buffer; a pop in the same cycle frees room for a push
	assign pop     = apb_done && !pwrite && (paddr == ADDR_DATA) && (count_q != 5'h00);
	assign push_ok = push_req && ((count_q != 5'(FIFO_DEPTH)) || pop);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push_ok) begin
				fifo_mem[wr_ptr_q] <= key_idx_q;
				wr_ptr_q           <= wr_ptr_q + 4'h1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 4'h1;
			end
			count_q <= count_q + {4'h0, push_ok} - {4'h0, pop};
		end
	end

	// Sticky status flags; a new event beats a software clear in the same cycle
	assign apb_wr = apb_done && pwrite && (paddr == ADDR_STATUS);
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ghost_q    <= 1'b0;
			ovf_q      <= 1'b0;
			mod_seen_q <= 1'b0;
		end else begin
			if ((state_q == KMS_SCAN) && tick && ghost_now) begin
				ghost_q <= 1'b1;
			end else if (apb_wr && pwdata[ST_GHOST_BIT]) begin
				ghost_q <= 1'b0;
			end
			if (push_req && !push_ok) begin
				ovf_q <= 1'b1;
			end else if (apb_wr && pwdata[ST_OVF_BIT]) begin
				ovf_q <= 1'b0;
			end
			if (mod_ev) begin
				mod_seen_q <= 1'b1;
			end else if (apb_wr && pwdata[ST_MOD_BIT]) begin
				mod_seen_q <= 1'b0;
			end
		end
	end

	// Control and modifier-map registers; out-of-range geometry is clamped to the legal span
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl_q.enable <= 1'b0;
			ctrl_q.cols   <= RST_COLS;
			ctrl_q.rows   <= RST_ROWS;
			mod_map_q     <= '0;
		end else if (apb_done && pwrite) begin
			if (paddr == ADDR_CTRL) begin
				ctrl_q.enable <= pwdata[CTRL_EN_BIT];
				if (pwdata[CTRL_COLS_LSB +: 5] == 5'h00) begin
					ctrl_q.cols <= 5'h01;
				end else if (pwdata[CTRL_COLS_LSB +: 5] > 5'(MAX_COLS)) begin
					ctrl_q.cols <= 5'(MAX_COLS);
				end else begin
					ctrl_q.cols <= pwdata[CTRL_COLS_LSB +: 5];
				end
				if (pwdata[CTRL_ROWS_LSB +: 4] == 4'h0) begin
					ctrl_q.rows <= 4'h1;
				end else if (pwdata[CTRL_ROWS_LSB +: 4] > 4'(MAX_ROWS)) begin
					ctrl_q.rows <= 4'(MAX_ROWS);
				end else begin
					ctrl_q.rows <= pwdata[CTRL_ROWS_LSB +: 4];
				end
			end
			for (int w = 0; w < MOD_WORDS; w++) begin
				if (paddr == ADDR_MOD0 + 8'(4 * w)) begin
					mod_map_q[w*32 +: 32] <= pwdata;
				end
			end
		end
	end

	// Read mux and status encoding
	always_comb begin
		unique case (state_q)
			KMS_IDLE: state_code = 2'h0;
			KMS_SCAN: state_code = 2'h1;
			KMS_END:  state_code = 2'h2;
			default:  state_code = 2'h3;
		endcase
		rd_d = 32'h0000_0000;
		if (paddr == ADDR_CTRL) begin
			rd_d[CTRL_EN_BIT]         = ctrl_q.enable;
			rd_d[CTRL_COLS_LSB +: 5]  = ctrl_q.cols;
			rd_d[CTRL_ROWS_LSB +: 4]  = ctrl_q.rows;
		end else if (paddr == ADDR_STATUS) begin
			rd_d[ST_GHOST_BIT]     = ghost_q;
			rd_d[ST_OVF_BIT]       = ovf_q;
			rd_d[ST_MOD_BIT]       = mod_seen_q;
			rd_d[ST_CLKR_BIT]      = clk_req;
			rd_d[ST_FSM_LSB +: 2]  = state_code;
			rd_d[ST_CNT_LSB +: 5]  = count_q;
		end else if (paddr == ADDR_DATA) begin
			rd_d[DATA_VALID_BIT] = (count_q != 5'h00);
			rd_d[7:0]            = (count_q != 5'h00) ? fifo_mem[rd_ptr_q] : 8'h00;
		end else begin
			for (int w = 0; w < MOD_WORDS; w++) begin
				if (paddr == ADDR_MOD0 + 8'(4 * w)) begin
					rd_d = mod_map_q[w*32 +: 32];
				end
			end
		end
	end

	// APB slave: one wait state, then pready; the transfer completes at the pready edge
	assign apb_done = psel && penable && pready;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h0000_0000 : rd_d;
			pslverr <= (paddr[1:0] != 2'b00) || (paddr > ADDR_MOD0 + 8'(4 * (MOD_WORDS - 1)));
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: verif/kms_chk.sv
// Port checker for the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
module kms_chk
	import kms_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = SCAN_DIV
) (
	input wire logic                clk_sys,
	input wire logic                sys_rst,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [MAX_COLS-1:0] col_out,
	input wire logic                clk_req
);
	logic [MAX_COLS-1:0] prev_col_q;
	logic [31:0]         hold_q;
	// Dwell counter per column drive; a change of drive restarts it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prev_col_q <= '1;
			hold_q     <= '0;
		end else begin
			prev_col_q <= col_out;
			hold_q     <= (col_out == prev_col_q) ? hold_q + 32'h0000_0001 : '0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	idle_cols_a: assert property (!clk_req |-> &col_out) else $error("columns not parked");
	col_shape_a: assert property ($onehot(col_out) || &col_out) else $error("column drive shape");
	scan_start_a: assert property ($rose(clk_req) |-> col_out[0] && $onehot(col_out)) else $error("scan start");
	// Dwell of at least one tick also catches a stuck tick divider
	col_step_a: assert property ($onehot(prev_col_q) && $onehot(col_out) && col_out != prev_col_q
		|-> col_out == prev_col_q << 1 && hold_q >= TICK_CYCLES - 1) else $error("column step");
	end_exit_a: assert property (clk_req && &col_out |=> !clk_req || (col_out[0] && $onehot(col_out)))
		else $error("scan end exit");
	dis_noreq_a: assert property (psel && penable && pready && pwrite && paddr == ADDR_CTRL
		&& !pwdata[CTRL_EN_BIT] |-> ##2 (!clk_req)[*3]) else $error("request while disabled");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready not a pulse");
	apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("access length");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	status_ok_a: assert property (pready && paddr == ADDR_STATUS |-> !pslverr) else $error("status refused");
	cover property ($rose(clk_req));
	cover property ($fell(clk_req));
	cover property (pslverr);
endmodule
bind kms_scanner kms_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.col_out(col_out), .clk_req(clk_req));
`default_nettype wire

// file: verif/kms_matrix.sv
// Passive key switch matrix: a closed switch ties its column to its row
`timescale 1ns/1ps
`default_nettype none
module kms_matrix
	import kms_pkg::*;
(
	input  wire logic [MAX_COLS-1:0] col_out,
	input  wire logic [MAX_KEYS-1:0] key_down,
	output logic      [MAX_ROWS-1:0] row_in
);
	// Rows have pull-downs, so an open row reads low; sneak paths are not modelled
	always_comb begin
		row_in = '0;
		for (int c = 0; c < MAX_COLS; c++) begin
			if (col_out[c]) begin
				row_in = row_in | key_down[c*MAX_ROWS +: MAX_ROWS];
			end
		end
	end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Testbench for the key matrix scanner
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import kms_pkg::*;
	logic                clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, clk_req, rd_e;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, rd_q;
	logic [MAX_ROWS-1:0] row_in;
	logic [MAX_COLS-1:0] col_out;
	logic [MAX_KEYS-1:0] key_down;
	int                  err_total, total_checks;
	// Short tick keeps a full pass at 640 clocks
	kms_scanner #(.TICK_CYCLES(4)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.row_in(row_in), .col_out(col_out), .clk_req(clk_req));
	kms_matrix u_mat (.col_out(col_out), .key_down(key_down), .row_in(row_in));
	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer, then an idle cycle so the next setup never lands in the same step
	// Waits on pready however long it takes; only the watchdog ends a hung transfer
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) begin
			@(posedge clk_sys);
		end
		rd_q = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		apb(1'b0, a, '0);
		while ((rd_q & m) !== v && n < 3000) begin
			apb(1'b0, a, '0);
			n++;
		end
		// A poll that runs out counts as a mismatch
		chk("poll wait", v, rd_q & m);
	endtask
	task automatic settle();
		key_down <= '0;
		poll(ADDR_STATUS, 32'h0000_0008, '0);
		chk("columns idle", 32'h000F_FFFF, 32'(col_out));
		apb(1'b1, ADDR_STATUS, 32'h0000_0007);
	endtask
	task automatic t_reset();
		apb(1'b0, ADDR_CTRL, '0);
		chk("ctrl reset", 32'h0008_1400, rd_q);
		apb(1'b0, ADDR_STATUS, '0);
		chk("status reset", '0, rd_q);
		apb(1'b0, 8'h40, '0);
		chk("unmapped", 32'h0000_0001, 32'(rd_e));
		chk("columns reset", 32'h000F_FFFF, 32'(col_out));
		// Geometry outside the legal span is clamped, scanner left disabled
		apb(1'b1, ADDR_CTRL, 32'h000F_1F00);
		apb(1'b0, ADDR_CTRL, '0);
		chk("ctrl clamp high", 32'h0008_1400, rd_q);
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
		apb(1'b0, ADDR_CTRL, '0);
		chk("ctrl clamp low", 32'h0001_0100, rd_q);
	endtask
	task automatic t_modifier();
		apb(1'b1, ADDR_MOD0, 32'h0000_0002);
		apb(1'b1, ADDR_CTRL, 32'h0002_0301);
		key_down[1] <= 1'b1;
		key_down[17] <= 1'b1;
		poll(ADDR_DATA, 32'h0000_0100, 32'h0000_0100);
		chk("key index", 32'h0000_0105, rd_q);
		apb(1'b0, ADDR_STATUS, '0);
		chk("modifier", 32'h0000_0004, rd_q & 32'h0000_1F07);
		settle();
		apb(1'b1, ADDR_MOD0, '0);
	endtask
	task automatic t_ghost();
		apb(1'b1, ADDR_CTRL, 32'h0002_0201);
		key_down[0] <= 1'b1;
		key_down[1] <= 1'b1;
		key_down[8] <= 1'b1;
		poll(ADDR_DATA, 32'h0000_0100, 32'h0000_0100);
		chk("first key", 32'h0000_0100, rd_q);
		apb(1'b0, ADDR_DATA, '0);
		chk("second key", 32'h0000_0101, rd_q);
		apb(1'b0, ADDR_STATUS, '0);
		chk("ghost", 32'h0000_0001, rd_q & 32'h0000_1F01);
		settle();
		apb(1'b0, ADDR_STATUS, '0);
		chk("ghost cleared", '0, rd_q & 32'h0000_0007);
	endtask
	task automatic t_overflow();
		apb(1'b1, ADDR_CTRL, 32'h0008_1401);
		for (int c = 0; c < 18; c++) begin
			key_down[c*8] <= 1'b1;
		end
		poll(ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
		chk("buffer full", 32'h0000_1002, rd_q & 32'h0000_1F02);
		settle();
		for (int c = 0; c < 16; c++) begin
			apb(1'b0, ADDR_DATA, '0);
			chk("buffer order", 32'h0000_0100 | 32'(c * 8), rd_q);
		end
		apb(1'b0, ADDR_DATA, '0);
		chk("buffer empty", '0, rd_q);
	endtask
	task automatic t_disable();
		key_down[3] <= 1'b1;
		poll(ADDR_STATUS, 32'h0000_0008, 32'h0000_0008);
		apb(1'b1, ADDR_CTRL, 32'h0008_1400);
		apb(1'b0, ADDR_STATUS, '0);
		chk("disabled", '0, rd_q & 32'h0000_0038);
		key_down <= '0;
	endtask
	// Watchdog
	initial begin
		#240000;
		err_total++;
		final_report();
	end
	// Main sequence
	initial begin
		{sys_rst, psel, penable, pwrite} = 4'h8;
		paddr = '0;
		pwdata = '0;
		key_down = '0;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_reset();
		t_modifier();
		t_ghost();
		t_overflow();
		t_disable();
		final_report();
	end
endmodule
`default_nettype wire
